// file: core/gcsr_pkg.sv
// What this block does
// - bit 12 picks first alert pin drive
// - bit 13 picks second alert pin drive
// - bit 14 halves frequency compare hysteresis
// - bit 15 lets halt pin stop sequencer
// - bit 16 takes coil currents from target
// - direct mode scales by standstill current
// - reset flag reads one after reset
// - undervolt flag set, driver disabled meanwhile
// - counter counts successful link writes
// - counter unchanged by reads, idle in spi
// - counter wraps from 255 to 0
package gcsr_pkg;
  // register offsets on the serial register port
  localparam logic [6:0] GCSR_OFS_CONFIG  = 7'h00;
  localparam logic [6:0] GCSR_OFS_STATUS  = 7'h01;
  localparam logic [6:0] GCSR_OFS_WRCNT   = 7'h02;
  // configuration field positions
  localparam int GCSR_CFG_W          = 18;
  localparam int GCSR_CFG_ALERT0_PP  = 12;
  localparam int GCSR_CFG_ALERT1_PP  = 13;
  localparam int GCSR_CFG_SMALL_HYST = 14;
  localparam int GCSR_CFG_STOP_EN    = 15;
  localparam int GCSR_CFG_DIRECT     = 16;
  localparam int GCSR_CFG_TEST       = 17;
  // status field positions
  localparam int GCSR_ST_W       = 3;
  localparam int GCSR_ST_RESET   = 0;
  localparam int GCSR_ST_DRV_ERR = 1;
  localparam int GCSR_ST_UV      = 2;
  // reset values
  localparam logic [17:0] GCSR_CFG_RST = 18'h00000;
  localparam logic [2:0]  GCSR_ST_RST  = 3'h1;
  localparam logic [7:0]  GCSR_CNT_RST = 8'h00;
  // hysteresis shifts: 1/16 and 1/32
  localparam int GCSR_HYST_SHIFT_WIDE  = 4;
  localparam int GCSR_HYST_SHIFT_SMALL = 5;
  // direct mode field layout in target position word
  localparam int GCSR_COIL_A_LSB = 0;
  localparam int GCSR_COIL_B_LSB = 16;
  localparam int GCSR_COIL_W     = 9;
  // standstill current width and scaling shift
  localparam int GCSR_HOLD_W      = 5;
  localparam int GCSR_SCALE_SHIFT = 5;
endpackage

// file: core/gcsr_alert_pin.sv
`timescale 1ns/1ns
// one open-collector or push-pull alert pin driver
module gcsr_alert_pin (
  input  wire logic clk_i,        // system clock
  input  wire logic resetn_i,     // async reset, active low
  input  wire logic pushpull_i,   // 1 push-pull high, 0 open collector low
  input  wire logic active_i,     // alert condition from core
  output logic      pin_o,        // pin output level
  output logic      pin_oe_o      // pin drive enable
);
  logic next_pin;   // next output level
  logic next_oe;    // next enable

  // open collector pulls low when active, push-pull drives level
  assign next_pin = pushpull_i ? active_i : 1'b0;
  assign next_oe  = pushpull_i ? 1'b1 : active_i;

  // registered pin drive, released at reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o    <= next_pin;
      pin_oe_o <= next_oe;
    end
  end
endmodule

// file: core/gcsr_regs.sv
`timescale 1ns/1ns
// global configuration, status and write counter registers
module gcsr_regs
  import gcsr_pkg::*;
#(
  parameter int FREQ_W = 20         // step frequency word width
) (
  input  wire logic              clk_i,          // system clock
  input  wire logic              resetn_i,       // async reset, active low
  input  wire logic [6:0]        reg_addr_i,     // register offset
  input  wire logic              reg_wr_i,       // write strobe, one cycle
  input  wire logic [31:0]       reg_wdata_i,    // write data
  input  wire logic              reg_rd_i,       // read strobe, one cycle
  output logic [31:0]            reg_rdata_o,    // read data, next cycle
  input  wire logic              uart_mode_i,    // 1 uart link, 0 spi
  input  wire logic              wr_ok_i,        // write frame passed checks
  input  wire logic [1:0]        alert_req_i,    // alert conditions
  output logic [1:0]             alert_pin_o,    // alert pin levels
  output logic [1:0]             alert_pin_oe_o, // alert pin enables
  input  wire logic [FREQ_W-1:0] step_freq_i,    // measured step frequency
  input  wire logic [FREQ_W-1:0] freq_thr_i,     // frequency threshold
  output logic                   freq_above_o,   // frequency above threshold
  input  wire logic              halt_pin_i,     // halt input pin, async
  input  wire logic              step_req_i,     // sequencer step request
  output logic                   step_o,         // step allowed to sequencer
  output logic                   standstill_o,   // motor held at standstill
  input  wire logic [31:0]       target_pos_i,   // target position register
  input  wire logic [4:0]        hold_cur_i,     // standstill current setting
  output logic                   direct_mode_o,  // direct coil current mode
  output logic [8:0]             coil_a_o,       // scaled signed coil a
  output logic [8:0]             coil_b_o,       // scaled signed coil b
  output logic                   autoscale_ok_o, // velocity regulation allowed
  output logic                   probe_test_o,   // analog test on index pin
  output logic [1:0]             probe_sel_o,    // analog test selection
  input  wire logic              drv_fault_i,    // driver shutdown event
  input  wire logic              drv_fault_on_i, // any error still present
  input  wire logic              pump_uv_i,      // pump undervolt, async
  output logic                   drv_disable_o   // driver disabled
);
  logic [17:0] cfg;          // global configuration
  logic [2:0]  status;       // global status flags
  logic [7:0]  wr_cnt;       // interface write counter
  logic [1:0]  halt_sync;    // halt pin synchroniser
  logic [1:0]  uv_sync;      // undervolt synchroniser
  logic        above;        // hysteresis comparator state

  // decode
  wire sel_cfg = reg_addr_i == GCSR_OFS_CONFIG;   // config selected
  wire sel_st  = reg_addr_i == GCSR_OFS_STATUS;   // status selected
  wire sel_cnt = reg_addr_i == GCSR_OFS_WRCNT;    // counter selected
  wire st_clr  = reg_rd_i && sel_st;              // clearing read
  wire halt_lv = halt_sync[1];                    // synchronised halt
  wire uv_lv   = uv_sync[1];                      // synchronised undervolt

  // read data mux, unmapped reads zero
  logic [31:0] next_rdata;
  assign next_rdata = sel_cfg ? {14'h0000, cfg} :
                      sel_st  ? {29'h00000000, status} :
                      sel_cnt ? {24'h000000, wr_cnt} : 32'h00000000;

  // read data register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i) reg_rdata_o <= next_rdata;
  end

  // configuration register, written by host
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) cfg <= GCSR_CFG_RST;
    else if (reg_wr_i && sel_cfg) cfg <= reg_wdata_i[17:0];
  end

  // status flags: hardware set wins over read clear
  logic [2:0] st_set;     // set terms
  logic [2:0] st_keep;    // flags kept on clearing read
  logic [2:0] next_status;
  assign st_set[GCSR_ST_RESET]   = 1'b0;
  assign st_set[GCSR_ST_DRV_ERR] = drv_fault_i;
  assign st_set[GCSR_ST_UV]      = uv_lv;
  assign st_keep = {1'b0, drv_fault_on_i, 1'b0};
  assign next_status = st_clr ? (st_set | (status & st_keep))
                              : (st_set | status);

  // status register, reset flag comes up set
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) status <= GCSR_ST_RST;
    else status <= next_status;
  end

  logic cnt_inc;
  assign cnt_inc = wr_ok_i && uart_mode_i;

  // interface counter, natural 8-bit wrap
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) wr_cnt <= GCSR_CNT_RST;
    else if (cnt_inc) wr_cnt <= wr_cnt + 8'h01;
  end

  // two-stage synchronisers for pin inputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_sync <= 2'h0;
      uv_sync   <= 2'h0;
    end else begin
      halt_sync <= {halt_sync[0], halt_pin_i};
      uv_sync   <= {uv_sync[0], pump_uv_i};
    end
  end

  assign drv_disable_o = uv_lv;

  logic stop_now;
  assign stop_now     = cfg[GCSR_CFG_STOP_EN] && halt_lv;
  assign step_o       = step_req_i && !stop_now;
  assign standstill_o = stop_now;

  logic [FREQ_W-1:0] hyst;     // band half width
  logic [FREQ_W:0]   upper;    // switch-on level
  logic [FREQ_W:0]   lower;    // switch-off level
  logic              next_above;
  assign hyst  = cfg[GCSR_CFG_SMALL_HYST] ?
                 (freq_thr_i >> GCSR_HYST_SHIFT_SMALL) :
                 (freq_thr_i >> GCSR_HYST_SHIFT_WIDE);
  assign upper = {1'b0, freq_thr_i} + {1'b0, hyst};
  assign lower = {1'b0, freq_thr_i} - {1'b0, hyst};
  assign next_above = above ? ({1'b0, step_freq_i} >= lower)
                            : ({1'b0, step_freq_i} > upper);

  // comparator state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) above <= 1'b0;
    else above <= next_above;
  end
  assign freq_above_o = above;

  logic signed [8:0]  raw_a;   // programmed coil a
  logic signed [8:0]  raw_b;   // programmed coil b
  logic signed [15:0] prod_a;  // scaled coil a
  logic signed [15:0] prod_b;  // scaled coil b
  logic signed [6:0]  scale;   // hold current plus one
  assign raw_a = target_pos_i[GCSR_COIL_A_LSB +: GCSR_COIL_W];
  assign raw_b = target_pos_i[GCSR_COIL_B_LSB +: GCSR_COIL_W];
  assign scale  = $signed({2'b00, hold_cur_i}) + 7'sh01;
  assign prod_a = raw_a * scale;
  assign prod_b = raw_b * scale;

  // coil current outputs, zero outside direct mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      coil_a_o <= 9'h000;
      coil_b_o <= 9'h000;
    end else if (cfg[GCSR_CFG_DIRECT]) begin
      coil_a_o <= prod_a[13:5];
      coil_b_o <= prod_b[13:5];
    end else begin
      coil_a_o <= 9'h000;
      coil_b_o <= 9'h000;
    end
  end
  assign direct_mode_o = cfg[GCSR_CFG_DIRECT];
  assign autoscale_ok_o = !cfg[GCSR_CFG_DIRECT];

  // test output, host keeps bit clear
  assign probe_test_o = cfg[GCSR_CFG_TEST];
  assign probe_sel_o  = cfg[GCSR_CFG_TEST] ? hold_cur_i[1:0] : 2'h0;

  // alert pin drivers, drive style per pin
  logic [1:0] alert_pp;
  assign alert_pp[0] = cfg[GCSR_CFG_ALERT0_PP];
  assign alert_pp[1] = cfg[GCSR_CFG_ALERT1_PP];
  for (genvar g = 0; g < 2; g++) begin : g_alert
    gcsr_alert_pin u_pin (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .pushpull_i (alert_pp[g]),
      .active_i   (alert_req_i[g]),
      .pin_o      (alert_pin_o[g]),
      .pin_oe_o   (alert_pin_oe_o[g])
    );
  end

  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  pin0_drive_a: assert property (cfg[12] && $stable(cfg[12])
    |=> alert_pin_oe_o[0] && alert_pin_o[0] == $past(alert_req_i[0]))
    else $error("first pin push-pull wrong");
  pin1_drive_a: assert property (!cfg[13] && $stable(cfg[13])
    |=> !alert_pin_o[1] && alert_pin_oe_o[1] == $past(alert_req_i[1]))
    else $error("second pin open collector wrong");
  hyst_band_a: assert property (!above && next_above |->
    {1'b0, step_freq_i} > {1'b0, freq_thr_i})
    else $error("comparator switched inside band");
  halt_stop_a: assert property (cfg[15] && halt_sync[1] |->
    !step_o && standstill_o)
    else $error("step passed during halt");
  direct_coil_a: assert property (cfg[16] && $stable(cfg[16])
    |=> coil_a_o == 9'($past(prod_a) >>> 5))
    else $error("coil a not from target");
  direct_auto_a: assert property (cfg[16] |-> !autoscale_ok_o)
    else $error("autoscale left on in direct mode");
  reset_flag_a: assert property ($rose(resetn_i) |-> status[0])
    else $error("reset flag not set");
  drv_err_hold_a: assert property (st_clr && drv_fault_on_i
    |=> status[1] == ($past(status[1]) | $past(drv_fault_i)))
    else $error("driver error cleared while present");
  uv_disable_a: assert property (uv_lv |-> drv_disable_o
    ##1 status[2])
    else $error("undervolt not flagged");
  cnt_inc_a: assert property (cnt_inc |=> wr_cnt ==
    8'($past(wr_cnt) + 8'h01))
    else $error("counter missed write");
  cnt_spi_a: assert property (!uart_mode_i || !wr_ok_i
    |=> $stable(wr_cnt))
    else $error("counter moved without uart write");
  cnt_wrap_a: assert property (cnt_inc && wr_cnt == 8'hff
    |=> wr_cnt == 8'h00)
    else $error("counter did not wrap");
  set_wins_a: assert property (st_clr && drv_fault_i
    |=> status[1])
    else $error("event lost on clearing read");

  cnt_wrap_c:  cover property (cnt_inc && wr_cnt == 8'hff);
  halt_c:      cover property (cfg[15] && halt_sync[1] && step_req_i);
  clr_race_c:  cover property (st_clr && drv_fault_i);
  direct_c:    cover property (cfg[16] && hold_cur_i == 5'h1f);
endmodule

// file: tb/gcsr_host.sv
`timescale 1ns/1ns
// host side of the register port, strobes move on falling edges
module gcsr_host (
  input  wire logic        clk_i,       // system clock
  output logic [6:0]       reg_addr_o,  // register offset
  output logic             reg_wr_o,    // write strobe
  output logic             reg_rd_o,    // read strobe
  output logic [31:0]      reg_wdata_o, // write data
  input  wire logic [31:0] reg_rdata_i  // read data
);
  // idle port at time zero
  initial begin
    reg_addr_o  = 7'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 32'h0;
  end
  // one write; released lines show inverted garbage
  // test bit set only when asked
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask
  // one read; data registered one cycle after strobe
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    d          = reg_rdata_i;
  endtask
endmodule

// file: tb/gcsr_regs_bench.sv
`timescale 1ns/1ns
module gcsr_regs_bench;
  import gcsr_pkg::*;
  // table row: config, alert requests, expected pins and modes
  typedef struct packed {
    logic [17:0] cfg;
    logic [1:0]  req, pin, oe;
    logic        dm, pt;
  } gcsr_row_t;
  logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, uart_mode_i, wr_ok_i;
  logic        halt_pin_i, step_req_i, drv_fault_i, drv_fault_on_i;
  logic        pump_uv_i, freq_above_o, step_o, standstill_o;
  logic        direct_mode_o, autoscale_ok_o, probe_test_o, drv_disable_o;
  logic [6:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, target_pos_i, rd;
  logic [1:0]  alert_req_i, alert_pin_o, alert_pin_oe_o, probe_sel_o;
  logic [19:0] step_freq_i, freq_thr_i;
  logic [8:0]  coil_a_o, coil_b_o;
  logic [4:0]  hold_cur_i;
  int          error_cnt, n_checks, cycles, i;
  gcsr_row_t   rows [6] = '{
    '{18'h00000, 2'h3, 2'h0, 2'h3, 1'b0, 1'b0},
    '{18'h03000, 2'h1, 2'h1, 2'h3, 1'b0, 1'b0},
    '{18'h01000, 2'h2, 2'h0, 2'h3, 1'b0, 1'b0},
    '{18'h02000, 2'h0, 2'h0, 2'h2, 1'b0, 1'b0},
    '{18'h10000, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0},
    '{18'h20000, 2'h1, 2'h0, 2'h1, 1'b0, 1'b1}};
  gcsr_regs u_dut (.*);
  gcsr_host u_host (
    .clk_i       (clk_i),
    .reg_addr_o  (reg_addr_i),
    .reg_wr_o    (reg_wr_i),
    .reg_rd_o    (reg_rd_i),
    .reg_wdata_o (reg_wdata_i),
    .reg_rdata_i (reg_rdata_o)
  );
  // 25 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test;
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // report and end
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // reset, then defaults and one-shot reset flag
  task automatic rst_chk;
    resetn_i = 1'b0;
    repeat (16) @(negedge clk_i);
    chk({freq_above_o, alert_pin_o, alert_pin_oe_o, coil_a_o, coil_b_o},
        32'h0);
    resetn_i = 1'b1;
    u_host.rd(GCSR_OFS_CONFIG, rd);
    chk(rd, 32'h0);
    u_host.rd(GCSR_OFS_WRCNT, rd);
    chk(rd, 32'h0);
    u_host.rd(GCSR_OFS_STATUS, rd);
    chk(rd, 32'h1);
    u_host.rd(GCSR_OFS_STATUS, rd);
    chk(rd, 32'h0);
  endtask
  // status read helper
  task automatic st(input logic [31:0] e);
    u_host.rd(GCSR_OFS_STATUS, rd);
    chk(rd, e);
  endtask
  // main sequence
  initial begin
    {uart_mode_i, wr_ok_i, halt_pin_i, step_req_i} = 4'h0;
    {drv_fault_i, drv_fault_on_i, pump_uv_i} = 3'h0;
    alert_req_i  = 2'h0;
    step_freq_i  = 20'h00690;
    freq_thr_i   = 20'h00640;
    target_pos_i = 32'h01c0_0040;
    hold_cur_i   = 5'h0f;
    rst_chk;
    // pin drive, modes, wide hysteresis
    for (i = 0; i < 6; i++) begin
      u_host.wr(GCSR_OFS_CONFIG, 32'(rows[i].cfg));
      alert_req_i = rows[i].req;
      repeat (2) @(negedge clk_i);
      chk({alert_pin_o, alert_pin_oe_o, direct_mode_o, autoscale_ok_o,
           probe_test_o, probe_sel_o, freq_above_o},
          {rows[i].pin, rows[i].oe, rows[i].dm, !rows[i].dm,
           rows[i].pt, rows[i].pt ? 2'h3 : 2'h0, 1'b0});
      u_host.rd(GCSR_OFS_CONFIG, rd);
      chk(rd, 32'(rows[i].cfg));
    end
    // direct coil currents and narrow hysteresis
    u_host.wr(GCSR_OFS_CONFIG, 32'h14000);
    repeat (2) @(negedge clk_i);
    chk({coil_a_o, coil_b_o, freq_above_o}, {9'h020, 9'h1e0, 1'b1});
    // narrow band: stays above until below thr minus thr/32
    step_freq_i = 20'h00622;
    repeat (2) @(negedge clk_i);
    chk(freq_above_o, 1'b1);
    step_freq_i = 20'h0060d;
    repeat (2) @(negedge clk_i);
    chk(freq_above_o, 1'b0);
    // halt pin stops steps
    u_host.wr(GCSR_OFS_CONFIG, 32'h08000);
    halt_pin_i = 1'b1;
    step_req_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({step_o, standstill_o}, 2'h1);
    halt_pin_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({step_o, standstill_o}, 2'h2);
    // halt pin ignored while stop enable is clear
    u_host.wr(GCSR_OFS_CONFIG, 32'h00000);
    halt_pin_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({step_o, standstill_o}, 2'h2);
    halt_pin_i = 1'b0;
    // counter: 255 writes, wrap, spi idle, refused writes
    uart_mode_i = 1'b1;
    wr_ok_i = 1'b1;
    repeat (255) @(negedge clk_i);
    wr_ok_i = 1'b0;
    u_host.rd(GCSR_OFS_WRCNT, rd);
    chk(rd, 32'hff);
    u_host.rd(GCSR_OFS_WRCNT, rd);
    chk(rd, 32'hff);
    wr_ok_i = 1'b1;
    @(negedge clk_i);
    uart_mode_i = 1'b0;
    repeat (3) @(negedge clk_i);
    wr_ok_i = 1'b0;
    u_host.wr(GCSR_OFS_WRCNT, 32'h55);
    u_host.rd(GCSR_OFS_WRCNT, rd);
    chk(rd, 32'h0);
    u_host.rd(7'h05, rd);
    chk(rd, 32'h0);
    // driver error held while faults remain
    drv_fault_on_i = 1'b1;
    drv_fault_i = 1'b1;
    @(negedge clk_i);
    drv_fault_i = 1'b0;
    st(32'h2);
    drv_fault_on_i = 1'b0;
    st(32'h2);
    fork
      st(32'h0);
      begin
        @(negedge clk_i);
        drv_fault_i = 1'b1;
        @(negedge clk_i);
        drv_fault_i = 1'b0;
      end
    join
    st(32'h2);
    st(32'h0);
    // pump undervolt flag and driver disable
    pump_uv_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(drv_disable_o, 1'b1);
    st(32'h4);
    st(32'h4);
    pump_uv_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(drv_disable_o, 1'b0);
    // second reset over dirty state
    uart_mode_i = 1'b1;
    u_host.wr(GCSR_OFS_CONFIG, 32'h3000);
    // leave the counter non-zero so reset has work to do
    wr_ok_i = 1'b1;
    @(negedge clk_i);
    wr_ok_i = 1'b0;
    rst_chk;
    stop_test;
  end
endmodule
